// ### hw/fci_map.vh
// Constants for the feeder command interface
`ifndef FCI_MAP_VH
`define FCI_MAP_VH
`define FCI_SLOT_W 8
`define FCI_NUM_SLOTS 8'h05
`define FCI_DIN_RELEASE 0
`define FCI_DIN_LIGHT 1
`define FCI_DIN_LOAD_LO 2
`define FCI_DIN_INT_LSB 5
`define FCI_DIN_INT_MSB 7
`define FCI_DISC_SLOTS 3
`define FCI_INT_STEPS 3'h7
`define FCI_FULL32 32'hffffffff
`define FCI_FREQ_MIN_W 6'h10
`define FCI_MODE_AUTO 1'b1
`define FCI_MODE_MANUAL 1'b0
`define FCI_RST_SLOT 8'h01
`endif

// ### hw/fci_top.v
// Feeder command interface: command interpreter for fieldbus and discrete I/O
`timescale 1ns/1ns
`include "fci_map.vh"
module fci_top (
	// Clock and reset
	input wire CLK_SYS,
	input wire SYS_RST,
	// Interface selection
	input wire DISCRETE_SEL,
	input wire CONVEY_CAPABLE,
	// Fieldbus mapping flags
	input wire MODE_MAPPED,
	input wire RELEASE_MAPPED,
	input wire DIR_MAPPED,
	// Fieldbus commands
	input wire [7:0] FB_SLOT,
	input wire FB_RESTART,
	input wire FB_MODE_NZ,
	input wire FB_RELEASE,
	input wire FB_LIGHT,
	input wire [31:0] FB_INTENSITY,
	input wire [31:0] FB_DIRECTION,
	input wire [31:0] FB_FREQ,
	input wire [5:0] FB_INT_W,
	input wire [5:0] FB_FREQ_W,
	input wire FB_PARAM_WR,
	// Configuration tool
	input wire TOOL_CONNECTED,
	input wire TOOL_PARAM_WR,
	input wire TOOL_RELOAD,
	// Stored slot table
	input wire [7:0] SLOT_DEFINED,
	input wire [7:0] SLOT_SEPARATING,
	// Discrete inputs
	input wire [7:0] DIN,
	// Fieldbus feedback
	output reg [7:0] FB_SLOT_ACTIVE,
	output reg DIR_UNAVAILABLE,
	output reg MODE_AUTO,
	// Drive outputs
	output reg RESTART_PULSE,
	output reg LOAD_PULSE,
	output reg [7:0] ACTIVE_SLOT,
	output reg ACT_ENABLE,
	output reg [31:0] VERT_INTENSITY,
	output reg [31:0] HORIZ_INTENSITY,
	output reg [31:0] DIRECTION,
	output reg [15:0] FREQ_X10,
	output reg LIGHT_ON,
	output reg FB_PARAM_OK,
	output reg TOOL_PARAM_OK,
	output reg FREQ_W_BAD,
	// Discrete outputs mirror the inputs
	output reg [7:0] DOUT
);
	// Synchroniser and previous-sample stages
	reg [7:0] din_meta_reg;
	reg [7:0] din_sync_reg;
	reg [7:0] din_prev_reg;
	reg [7:0] fb_slot_prev_reg;
	reg restart_prev_reg;
	reg tool_prev_reg;
	reg release_auto_reg;
	// Combinational next values
	reg mode_next;
	reg release_auto_next;
	reg [7:0] slot_next;
	reg load_next;
	reg [31:0] int_full;
	reg [63:0] prod;
	reg [63:0] quot;
	reg [31:0] int_scaled;
	reg [31:0] fb_int_clamped;
	reg release_eff;
	reg [31:0] int_req;
	reg light_req;
	reg [31:0] vert_next;
	reg [31:0] horiz_next;
	reg act_next;
	reg light_next;
	reg [31:0] dir_next;
	reg freq_ok;
	// Decoded events
	wire fb_restart_fall;
	wire tool_drop;
	wire slot_changed;
	wire slot_ok;
	wire [2:0] int_code;
	wire [2:0] disc_load;
	wire mode_fb_ctrl;
	wire fb_wr_ok;
	wire tool_wr_ok;
	genvar gi;

	// Edges from the registered previous sample and the live input
	assign fb_restart_fall = restart_prev_reg & ~FB_RESTART;
	assign tool_drop = tool_prev_reg & ~TOOL_CONNECTED;
	assign slot_changed = FB_SLOT != fb_slot_prev_reg;
	assign int_code = din_sync_reg[`FCI_DIN_INT_MSB:`FCI_DIN_INT_LSB];
	// Table index masked to three bits; slots above five never load
	assign slot_ok = (FB_SLOT != 8'h00) && (FB_SLOT <= `FCI_NUM_SLOTS) &&
		SLOT_DEFINED[FB_SLOT[2:0]];
	// Fieldbus owns the mode only with no tool and a mapped command
	assign mode_fb_ctrl = !TOOL_CONNECTED && MODE_MAPPED &&
		!DISCRETE_SEL;
	assign fb_wr_ok = FB_PARAM_WR & MODE_AUTO;
	assign tool_wr_ok = TOOL_PARAM_WR & ~MODE_AUTO;

	// Rising edges on discrete load inputs, one per slot
	generate
		for (gi = 0; gi < `FCI_DISC_SLOTS; gi = gi + 1) begin : g_load
			assign disc_load[gi] = din_sync_reg[`FCI_DIN_LOAD_LO + gi] &
				~din_prev_reg[`FCI_DIN_LOAD_LO + gi];
		end
	endgenerate

	// Ownership mode; a restart outranks every other source
	always @* begin
		mode_next = MODE_AUTO;
		if (fb_restart_fall) begin
			mode_next = `FCI_MODE_AUTO;
		end else if (tool_drop) begin
			mode_next = `FCI_MODE_AUTO;
		end else if (mode_fb_ctrl) begin
			// Mapped command is a level; zero falls back to manual
			mode_next = FB_MODE_NZ;
		end
	end

	// Auto release latches on entry to automatic mode when unmapped
	// Trade-off: never revoked, so a later manual spell keeps it set
	always @* begin
		release_auto_next = release_auto_reg;
		if (!RELEASE_MAPPED && !MODE_AUTO && mode_next) begin
			release_auto_next = 1'b1;
		end
	end

	// Slot selection from discrete loads or a changed fieldbus number
	always @* begin
		slot_next = ACTIVE_SLOT;
		load_next = 1'b0;
		if (DISCRETE_SEL) begin
			if (disc_load[0] && SLOT_DEFINED[1]) begin
				slot_next = 8'h01;
				load_next = 1'b1;
			end else if (disc_load[1] && SLOT_DEFINED[2]) begin
				slot_next = 8'h02;
				load_next = 1'b1;
			end else if (disc_load[2] && SLOT_DEFINED[3]) begin
				slot_next = 8'h03;
				load_next = 1'b1;
			end
		end else if (slot_changed && slot_ok) begin
			slot_next = FB_SLOT;
			load_next = 1'b1;
		end
		// Reload keeps the slot and only repeats the load
		if (TOOL_RELOAD) begin
			load_next = 1'b1;
		end
	end

	// Full scale of the configured width; zero or above 32 means 32
	always @* begin
		if (FB_INT_W == 6'h00 || FB_INT_W > 6'h20) begin
			int_full = `FCI_FULL32;
		end else begin
			int_full = `FCI_FULL32 >> (6'h20 - FB_INT_W);
		end
	end

	// Discrete code in seven equal steps, truncated toward zero
	always @* begin
		prod = {32'h0, int_full} * {61'h0, int_code};
		quot = prod / 64'h7;
		int_scaled = quot[31:0];
		if (int_scaled > int_full) begin
			int_scaled = int_full;
		end
	end

	// Raw fieldbus intensity clamped to the width's full scale
	always @* begin
		if (FB_INTENSITY > int_full) begin
			fb_int_clamped = int_full;
		end else begin
			fb_int_clamped = FB_INTENSITY;
		end
	end

	// Release, intensity and light requests for the next cycle
	always @* begin
		if (DISCRETE_SEL) begin
			release_eff = din_sync_reg[`FCI_DIN_RELEASE];
			int_req = int_scaled;
			light_req = din_sync_reg[`FCI_DIN_LIGHT];
		end else begin
			release_eff = RELEASE_MAPPED ? FB_RELEASE :
				release_auto_reg;
			int_req = fb_int_clamped;
			light_req = FB_LIGHT;
		end
		light_next = light_req & release_eff;
		act_next = 1'b0;
		vert_next = 32'h0;
		horiz_next = 32'h0;
		if (release_eff && int_req != 32'h0) begin
			act_next = 1'b1;
			vert_next = int_req;
			horiz_next = int_req;
			if (SLOT_SEPARATING[slot_next[2:0]] || !CONVEY_CAPABLE) begin
				horiz_next = 32'h0;
			end
		end
	end

	// Direction only on conveying parts driven from the fieldbus
	always @* begin
		if (CONVEY_CAPABLE && !DISCRETE_SEL) begin
			dir_next = FB_DIRECTION;
		end else begin
			dir_next = 32'h0;
		end
		freq_ok = fb_wr_ok && FB_FREQ_W >= `FCI_FREQ_MIN_W;
	end

	// Synchroniser and previous samples for edge detection
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			din_meta_reg <= 8'h00;
			din_sync_reg <= 8'h00;
			din_prev_reg <= 8'h00;
			fb_slot_prev_reg <= 8'h00;
			restart_prev_reg <= 1'b0;
			tool_prev_reg <= 1'b0;
		end else begin
			din_meta_reg <= DIN;
			din_sync_reg <= din_meta_reg;
			din_prev_reg <= din_sync_reg;
			fb_slot_prev_reg <= FB_SLOT;
			restart_prev_reg <= FB_RESTART;
			tool_prev_reg <= TOOL_CONNECTED;
		end
	end

	// Restart pulse and ownership mode; reset counts as a restart
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			RESTART_PULSE <= 1'b0;
			MODE_AUTO <= `FCI_MODE_AUTO;
			release_auto_reg <= 1'b0;
		end else begin
			RESTART_PULSE <= fb_restart_fall;
			MODE_AUTO <= mode_next;
			release_auto_reg <= release_auto_next;
		end
	end

	// Slot selection and load feedback
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			LOAD_PULSE <= 1'b0;
			ACTIVE_SLOT <= `FCI_RST_SLOT;
			FB_SLOT_ACTIVE <= 8'h00;
		end else begin
			LOAD_PULSE <= load_next;
			ACTIVE_SLOT <= slot_next;
			if (load_next) begin
				FB_SLOT_ACTIVE <= slot_next;
			end
		end
	end

	// Parameter ownership gates and frequency
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			FB_PARAM_OK <= 1'b0;
			TOOL_PARAM_OK <= 1'b0;
			FREQ_W_BAD <= 1'b0;
			FREQ_X10 <= 16'h0;
		end else begin
			FB_PARAM_OK <= fb_wr_ok;
			TOOL_PARAM_OK <= tool_wr_ok;
			// Tenths of hertz need 16 bits or more
			FREQ_W_BAD <= FB_FREQ_W < `FCI_FREQ_MIN_W;
			if (freq_ok) begin
				FREQ_X10 <= FB_FREQ[15:0];
			end
		end
	end

	// Power outputs and light gated by the release; direction, flags and DOUT are not
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			ACT_ENABLE <= 1'b0;
			VERT_INTENSITY <= 32'h0;
			HORIZ_INTENSITY <= 32'h0;
			DIRECTION <= 32'h0;
			LIGHT_ON <= 1'b0;
			DIR_UNAVAILABLE <= 1'b0;
			DOUT <= 8'h00;
		end else begin
			ACT_ENABLE <= act_next;
			VERT_INTENSITY <= vert_next;
			HORIZ_INTENSITY <= horiz_next;
			DIRECTION <= dir_next;
			LIGHT_ON <= light_next;
			DIR_UNAVAILABLE <= DIR_MAPPED & ~CONVEY_CAPABLE;
			DOUT <= din_sync_reg;
		end
	end
endmodule // fci_top

// ### tb/fci_chk.sv
// Assertion checker for the feeder command interface
`timescale 1ns/1ns
module fci_chk (
	// Clock, reset and setup
	input wire CLK_SYS, SYS_RST, DISCRETE_SEL, CONVEY_CAPABLE, MODE_MAPPED,
	input wire RELEASE_MAPPED, DIR_MAPPED, TOOL_CONNECTED,
	// Fieldbus commands and slot table
	input wire [7:0] FB_SLOT, SLOT_DEFINED,
	input wire FB_RESTART, FB_RELEASE, FB_PARAM_WR,
	// Outputs
	input wire [7:0] FB_SLOT_ACTIVE, ACTIVE_SLOT,
	input wire DIR_UNAVAILABLE, MODE_AUTO, RESTART_PULSE, LOAD_PULSE,
	input wire LIGHT_ON, FB_PARAM_OK,
	input wire [31:0] VERT_INTENSITY, HORIZ_INTENSITY
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	// Index masked to three bits so an out-of-range slot never reads unknown
	wire slot_ok = FB_SLOT != 8'h00 && FB_SLOT < 8'h06 &&
		SLOT_DEFINED[FB_SLOT[2:0]];
	sequence s_fall; FB_RESTART ##1 !FB_RESTART; endsequence
	sequence s_new; !DISCRETE_SEL && FB_SLOT != $past(FB_SLOT); endsequence
	a_restart_fall:
	assert property (s_fall |=> RESTART_PULSE && MODE_AUTO)
		else $error("restart not issued after request fall");
	a_restart_rise:
	assert property ($rose(FB_RESTART) |=> !RESTART_PULSE)
		else $error("restart issued on request rise");
	a_slot_load:
	assert property (s_new ##0 slot_ok |=> LOAD_PULSE &&
		ACTIVE_SLOT == $past(FB_SLOT) && FB_SLOT_ACTIVE == $past(FB_SLOT))
		else $error("valid slot not loaded");
	a_slot_bad:
	assert property (s_new ##0 !slot_ok |=> !LOAD_PULSE && $stable(ACTIVE_SLOT))
		else $error("invalid slot acted on");
	a_slot_hold:
	assert property (ACTIVE_SLOT != $past(ACTIVE_SLOT) |-> LOAD_PULSE)
		else $error("active slot changed without load");
	a_rel_off:
	assert property ((!DISCRETE_SEL && RELEASE_MAPPED && !FB_RELEASE)[*2] |->
		!LIGHT_ON && VERT_INTENSITY == 32'h0)
		else $error("outputs on without release");
	a_tool_hold:
	assert property (TOOL_CONNECTED[*2] ##0 !RESTART_PULSE |-> $stable(MODE_AUTO))
		else $error("mode changed while tool connected");
	a_tool_drop:
	assert property ($fell(TOOL_CONNECTED) && !MODE_MAPPED |-> ##[1:2] MODE_AUTO)
		else $error("no automatic mode after tool drop");
	a_fb_param:
	assert property (FB_PARAM_WR ##1 $stable(MODE_AUTO) |->
		FB_PARAM_OK == MODE_AUTO)
		else $error("fieldbus write acceptance wrong");
	a_no_dir:
	assert property ((!CONVEY_CAPABLE && DIR_MAPPED)[*2] |->
		DIR_UNAVAILABLE && HORIZ_INTENSITY == 32'h0)
		else $error("direction used on non conveying part");
endmodule // fci_chk
bind fci_top fci_chk u_chk (.*);

// ### tb/fci_ctrl_model.sv
// Model of the machine controller driving mode and release commands
`timescale 1ns/1ns
module fci_ctrl_model (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Requests from the sequence
	input wire want_auto,
	input wire want_release,
	// Fieldbus commands
	output reg mode_nz,
	output reg release_cmd
);
	// Mode is held every cycle, never pulsed, else the unit drops to manual
	always @(posedge clk) begin
		if (rst) begin
			mode_nz <= 1'b1;
			release_cmd <= 1'b0;
		end else begin
			mode_nz <= want_auto;
			release_cmd <= want_release;
		end
	end
endmodule // fci_ctrl_model

// ### tb/fci_top_tb_top.sv
// Self-checking testbench for the feeder command interface
`timescale 1ns/1ns
module fci_top_tb_top;
	reg CLK_SYS = 1'b0;
	reg SYS_RST = 1'b1;
	reg DISCRETE_SEL, CONVEY_CAPABLE, MODE_MAPPED, RELEASE_MAPPED, DIR_MAPPED;
	reg FB_RESTART, FB_LIGHT, FB_PARAM_WR, TOOL_CONNECTED, TOOL_PARAM_WR;
	reg TOOL_RELOAD, auto_req, rel_req;
	reg [7:0] FB_SLOT, SLOT_DEFINED, SLOT_SEPARATING, DIN;
	reg [31:0] FB_INTENSITY, FB_DIRECTION, FB_FREQ;
	reg [5:0] FB_INT_W, FB_FREQ_W;
	wire FB_MODE_NZ, FB_RELEASE, DIR_UNAVAILABLE, MODE_AUTO, RESTART_PULSE;
	wire LOAD_PULSE, ACT_ENABLE, LIGHT_ON, FB_PARAM_OK, TOOL_PARAM_OK;
	wire FREQ_W_BAD;
	wire [7:0] FB_SLOT_ACTIVE, ACTIVE_SLOT, DOUT;
	wire [31:0] VERT_INTENSITY, HORIZ_INTENSITY, DIRECTION;
	wire [15:0] FREQ_X10;
	integer n_mismatch = 0;
	integer num_checks = 0;
	integer cyc = 0;
	fci_top u_dut (.*);
	fci_ctrl_model u_ctrl (.clk(CLK_SYS), .rst(SYS_RST), .want_auto(auto_req),
		.want_release(rel_req), .mode_nz(FB_MODE_NZ), .release_cmd(FB_RELEASE));
	always #50 CLK_SYS = ~CLK_SYS;
	task step(input integer n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	task chk(input [79:0] nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch %0s exp %h got %h", nm, exp, got);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Both write strobes at once; only the owner of the parameters may win
	task pw(input logic fb_ok);
		@(posedge CLK_SYS) {FB_PARAM_WR, TOOL_PARAM_WR} <= 2'h3;
		@(posedge CLK_SYS) {FB_PARAM_WR, TOOL_PARAM_WR} <= 2'h0;
		#1;
		chk("fb_wr", fb_ok, FB_PARAM_OK);
		chk("tool_wr", !fb_ok, TOOL_PARAM_OK);
	endtask
	task t_slot;
		@(posedge CLK_SYS) FB_SLOT <= 8'h02;
		step(1);
		chk("load", 1, LOAD_PULSE);
		chk("slot", 2, ACTIVE_SLOT);
		@(posedge CLK_SYS) FB_SLOT <= 8'h00;
		step(2);
		@(posedge CLK_SYS) FB_SLOT <= 8'h04;
		step(2);
		chk("slot", 2, ACTIVE_SLOT);
		chk("fb_slot", 2, FB_SLOT_ACTIVE);
		$display("t_slot end");
	endtask
	task t_mode;
		@(posedge CLK_SYS) MODE_MAPPED <= 1'b1;
		step(3);
		chk("auto", 0, MODE_AUTO);
		pw(1'b0);
		@(posedge CLK_SYS) TOOL_CONNECTED <= 1'b1;
		@(posedge CLK_SYS) auto_req <= 1'b1;
		step(3);
		chk("auto", 0, MODE_AUTO);
		@(posedge CLK_SYS) MODE_MAPPED <= 1'b0;
		@(posedge CLK_SYS) TOOL_CONNECTED <= 1'b0;
		step(3);
		chk("auto", 1, MODE_AUTO);
		pw(1'b1);
		@(posedge CLK_SYS) auto_req <= 1'b0;
		@(posedge CLK_SYS) MODE_MAPPED <= 1'b1;
		step(3);
		@(posedge CLK_SYS) TOOL_CONNECTED <= 1'b1;
		@(posedge CLK_SYS) FB_RESTART <= 1'b1;
		step(2);
		chk("restart", 0, RESTART_PULSE);
		@(posedge CLK_SYS) FB_RESTART <= 1'b0;
		step(1);
		chk("restart", 1, RESTART_PULSE);
		chk("auto", 1, MODE_AUTO);
		@(posedge CLK_SYS) MODE_MAPPED <= 1'b0;
		@(posedge CLK_SYS) TOOL_CONNECTED <= 1'b0;
		step(3);
		$display("t_mode end");
	endtask
	task t_out;
		chk("light", 0, LIGHT_ON);
		chk("vert", 0, VERT_INTENSITY);
		@(posedge CLK_SYS) rel_req <= 1'b1;
		step(3);
		chk("light", 1, LIGHT_ON);
		chk("vert", 32'hffffffff, VERT_INTENSITY);
		chk("act", 1, ACT_ENABLE);
		chk("dir", 32'h5a, DIRECTION);
		chk("freq_bad", 1, FREQ_W_BAD);
		@(posedge CLK_SYS) {FB_INT_W, FB_FREQ_W} <= 12'h210;
		@(posedge CLK_SYS) FB_INTENSITY <= 32'h1ff;
		pw(1'b1);
		chk("vert", 32'hff, VERT_INTENSITY);
		chk("freq", 16'h234, FREQ_X10);
		chk("freq_bad", 0, FREQ_W_BAD);
		@(posedge CLK_SYS) SLOT_SEPARATING <= 8'h04;
		pw(1'b1);
		chk("horiz", 0, HORIZ_INTENSITY);
		@(posedge CLK_SYS) DIR_MAPPED <= 1'b1;
		@(posedge CLK_SYS) CONVEY_CAPABLE <= 1'b0;
		step(2);
		chk("dir_na", 1, DIR_UNAVAILABLE);
		chk("dir", 0, DIRECTION);
		@(posedge CLK_SYS) FB_INTENSITY <= 32'h0;
		pw(1'b1);
		chk("vert", 0, VERT_INTENSITY);
		chk("act", 0, ACT_ENABLE);
		$display("t_out end");
	endtask
	task t_disc;
		@(posedge CLK_SYS) DISCRETE_SEL <= 1'b1;
		@(posedge CLK_SYS) DIN <= 8'h01;
		step(5);
		@(posedge CLK_SYS) DIN <= 8'he5;
		step(6);
		chk("slot", 1, ACTIVE_SLOT);
		chk("vert", 32'hff, VERT_INTENSITY);
		chk("light", 0, LIGHT_ON);
		chk("dout", 8'he5, DOUT);
		@(posedge CLK_SYS) DIN <= 8'h61;
		step(6);
		chk("vert", 32'h6d, VERT_INTENSITY);
		@(posedge CLK_SYS) DIN <= 8'h01;
		step(6);
		chk("vert", 0, VERT_INTENSITY);
		chk("slot", 1, ACTIVE_SLOT);
		$display("t_disc end");
	endtask
	// Whole run needs under a hundred cycles; the ceiling leaves ample margin
	always @(posedge CLK_SYS) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			n_mismatch = n_mismatch + 1;
			end_sim;
		end
	end
	initial begin
		{DISCRETE_SEL, MODE_MAPPED, DIR_MAPPED, FB_RESTART, FB_PARAM_WR} = 5'h0;
		{TOOL_CONNECTED, TOOL_PARAM_WR, TOOL_RELOAD, auto_req, rel_req} = 5'h0;
		{CONVEY_CAPABLE, RELEASE_MAPPED, FB_LIGHT} = 3'h7;
		{FB_SLOT, SLOT_SEPARATING, DIN, FB_INT_W, FB_FREQ_W} = 36'h0;
		SLOT_DEFINED = 8'h2e;
		FB_INTENSITY = 32'hffffffff;
		FB_DIRECTION = 32'h5a;
		FB_FREQ = 32'h234;
		repeat (3) @(posedge CLK_SYS);
		SYS_RST <= 1'b0;
		t_slot;
		t_mode;
		t_out;
		t_disc;
		end_sim;
	end
endmodule // fci_top_tb_top
